//--- verilog/sls_consts.svh
// Offsets, field positions, reset values and codes of the setup lock block
`ifndef SLS_CONSTS_SVH
`define SLS_CONSTS_SVH
`define SLS_ADDR_W        4
`define SLS_OFF_SETUP     4'h0
`define SLS_OFF_LOCK      4'h1
`define SLS_OFF_INHIBIT   4'h2
`define SLS_OFF_RESTORE   4'h3
`define SLS_OFF_OUTMODE   4'h4
`define SLS_OFF_TARGET    4'h5
`define SLS_OFF_PARAM     4'h6
`define SLS_OFF_STATUS    4'h7
`define SLS_OFF_COMMIT    4'h8
`define SLS_OFF_PANEL     4'h9
`define SLS_BIT_DI_EN     0
`define SLS_BIT_PO_RUN    1
`define SLS_BIT_CONFIRM   1
`define SLS_RST_LOCK      2'h0
`define SLS_RST_OUTMODE   1'h1
`define SLS_RST_TARGET    16'h0000
`define SLS_RST_PARAM     16'h0000
`define SLS_LOCK_PANEL    2'h2
`define SLS_CONF_NONE     2'h0
`define SLS_CONF_YES      2'h1
`define SLS_CONF_NO       2'h2
`endif

//--- verilog/sls_pkg.sv
// Types of the setup lock block
package sls_pkg;
    typedef enum logic [2:0] {
        SLS_LOAD    = 3'h1,
        SLS_IDLE    = 3'h2,
        SLS_CONFIRM = 3'h4
    } sls_state_t;
    typedef enum logic [1:0] {
        SLS_OPT_NONE = 2'h0,
        SLS_OPT_TWO  = 2'h1,
        SLS_OPT_FOUR = 2'h2
    } sls_opt_t;
endpackage

//--- verilog/sls_setup_lock.sv
// Setup lock, restore handshake and contact input decode
//
// Function
// - Contacts act only when enabled and fitted
// - Two inputs: run/stop and target one/four
// - Four inputs: run/stop, two bits select target
// - Power-up state follows run select setting
// - Restore request only opens confirmation step
// - Yes restores defaults, no abandons restore
// - Lock levels zero, one, two gate writes
// - Locked parameters still readable
// - Panel key lock sets level two
// - Locked panel edit blinks until key
// - Inhibit keeps communication writes volatile only
// - Lock, inhibit and confirmed restore always committed
// - Reset reloads volatile from nonvolatile copy; output mode takes its reset default
// - Primary output on/off or PID selectable
`timescale 1ns/10ps
`include "sls_consts.svh"
module sls_setup_lock #(
    parameter int DW = 16                        // Parameter width
) (
    input  wire logic             clk_in,              // 20 MHz clock
    input  wire logic             rstn_in,             // Sync reset, low
    input  wire logic [3:0]       avs_address_in,      // Word address
    input  wire logic             avs_read_in,         // Read request
    input  wire logic             avs_write_in,        // Write request
    input  wire logic [31:0]      avs_writedata_in,    // Write data
    output logic      [31:0]      avs_readdata_out,    // Read data
    output logic                  avs_waitrequest_out, // Wait
    input  wire sls_pkg::sls_opt_t contact_option_in,  // Fitted option
    input  wire logic [3:0]       contact_input_in,    // Field contacts
    input  wire logic             nv_setup_in,         // Stored enable
    input  wire logic             nv_powerup_run_in,   // Stored run select
    input  wire logic [1:0]       nv_lock_in,          // Stored lock
    input  wire logic             nv_inhibit_in,       // Stored inhibit
    input  wire logic [DW-1:0]    nv_target_in,        // Stored target
    input  wire logic [DW-1:0]    nv_param_in,         // Stored parameter
    input  wire logic             key_lock_combo_in,   // Panel lock keys
    input  wire logic             key_set_in,          // Panel set key
    input  wire logic             key_clear_in,        // Down/up/mode key
    output logic                  run_out,             // Controlling state
    output logic      [1:0]       target_select_out,   // Target 1..4/remote
    output logic                  alarm_latch_reset_out, // Reset latches
    output logic                  primary_output_mode_out, // 1 PID 0 on/off
    output logic                  lock_blink_out,      // Lock indicator
    output logic                  nv_commit_out,       // Commit pulse
    output logic      [3:0]       nv_commit_addr_out   // Committed reg
);
    import sls_pkg::*;

    // ====================================================
    // Storage
    sls_state_t  state;
    logic        input_function_enable;
    logic        powerup_run_select;
    logic [1:0]  lock_level;
    logic        nonvolatile_write_inhibit;
    logic        primary_output_mode;
    logic [DW-1:0] target_value;
    logic [DW-1:0] param_value;
    logic        run_state;
    logic        restore_req;
    logic        ack;
    logic        blink;
    logic        key_lock_q;

    function automatic logic lock_blocks(input logic [3:0] a, input logic [1:0] lv);
        // Only the lock escapes level one; level two also frees the targets
        if (a == `SLS_OFF_LOCK) return 1'b0;
        if (lv == 2'h2 && a == `SLS_OFF_TARGET) return 1'b0;
        return lv != 2'h0;
    endfunction

    // ====================================================
    // Bus decode
    wire       req      = avs_read_in | avs_write_in;
    // Taken while waitrequest is high; a write lands only at the edge where waitrequest is low,
    // so a master that stalls never sees a half-finished transfer
    wire       ready    = (state != SLS_LOAD) & ~ack;
    wire       wr_go    = avs_write_in & ack;
    wire       rd_go    = avs_read_in & ready;
    wire [3:0] addr     = avs_address_in;
    wire       blocked  = lock_blocks(addr, lock_level);
    wire       wr_ok    = wr_go & ~blocked;
    wire [15:0] wd      = avs_writedata_in[15:0];
    wire contact_active = input_function_enable & (contact_option_in != SLS_OPT_NONE);
    wire four = contact_option_in == SLS_OPT_FOUR;
    wire [1:0] next_target = four ? {contact_input_in[2], contact_input_in[1]}
                                  : {contact_input_in[1], contact_input_in[1]};
    wire       restore_yes = wr_ok & (addr == `SLS_OFF_RESTORE) & restore_req
                             & (wd[1:0] == `SLS_CONF_YES);
    wire       restore_no  = wr_ok & (addr == `SLS_OFF_RESTORE) & restore_req
                             & (wd[1:0] == `SLS_CONF_NO);
    wire       always_commit = (addr == `SLS_OFF_LOCK) | (addr == `SLS_OFF_INHIBIT);
    wire       next_commit = wr_ok & (always_commit | ~nonvolatile_write_inhibit)
                             & (addr != `SLS_OFF_RESTORE);

    assign avs_waitrequest_out = req & ~ack;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            `SLS_OFF_SETUP:   rd_mux = {30'h0, powerup_run_select, input_function_enable};
            `SLS_OFF_LOCK:    rd_mux = {30'h0, lock_level};
            `SLS_OFF_INHIBIT: rd_mux = {31'h0, nonvolatile_write_inhibit};
            `SLS_OFF_RESTORE: rd_mux = {30'h0, restore_req, 1'b0};
            `SLS_OFF_OUTMODE: rd_mux = {31'h0, primary_output_mode};
            `SLS_OFF_TARGET:  rd_mux = 32'(target_value);
            `SLS_OFF_PARAM:   rd_mux = 32'(param_value);
            `SLS_OFF_STATUS:  rd_mux = {27'h0, blink, run_state, target_select_out, alarm_latch_reset_out};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // ====================================================
    // Handshake: one wait cycle, then answer
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ack              <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack <= req & ready;
            if (rd_go) begin
                avs_readdata_out <= rd_mux;
            end
        end
    end

    // ====================================================
    // Setup state
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            state                     <= SLS_LOAD;
            input_function_enable     <= 1'b0;
            powerup_run_select        <= 1'b0;
            lock_level                <= `SLS_RST_LOCK;
            nonvolatile_write_inhibit <= 1'b0;
            primary_output_mode       <= `SLS_RST_OUTMODE;
            target_value              <= `SLS_RST_TARGET;
            param_value               <= `SLS_RST_PARAM;
            run_state                 <= 1'b0;
            restore_req               <= 1'b0;
        end else begin
            case (state)
                SLS_LOAD: begin
                    input_function_enable     <= nv_setup_in;
                    powerup_run_select        <= nv_powerup_run_in;
                    lock_level                <= nv_lock_in;
                    nonvolatile_write_inhibit <= nv_inhibit_in;
                    target_value              <= nv_target_in;
                    param_value               <= nv_param_in;
                    run_state                 <= nv_powerup_run_in;
                    state                     <= SLS_IDLE;
                end
                SLS_IDLE, SLS_CONFIRM: begin
                    if (key_lock_combo_in && !key_lock_q) begin
                        lock_level <= `SLS_LOCK_PANEL;
                    end else if (wr_ok && addr == `SLS_OFF_LOCK && wd[1:0] != 2'h3) begin
                        lock_level <= wd[1:0];
                    end
                    if (wr_ok && addr == `SLS_OFF_SETUP) begin
                        input_function_enable <= wd[`SLS_BIT_DI_EN];
                        powerup_run_select    <= wd[`SLS_BIT_PO_RUN];
                    end
                    if (wr_ok && addr == `SLS_OFF_INHIBIT) nonvolatile_write_inhibit <= wd[0];
                    if (wr_ok && addr == `SLS_OFF_OUTMODE) primary_output_mode <= wd[0];
                    if (wr_ok && addr == `SLS_OFF_TARGET) target_value <= wd[DW-1:0];
                    if (wr_ok && addr == `SLS_OFF_PARAM) param_value <= wd[DW-1:0];
                    if (wr_ok && addr == `SLS_OFF_RESTORE && !restore_req && wd[0]) begin
                        restore_req <= 1'b1;
                        state       <= SLS_CONFIRM;
                    end
                    if (restore_no) begin
                        restore_req <= 1'b0;
                        state       <= SLS_IDLE;
                    end
                    if (restore_yes) begin
                        restore_req               <= 1'b0;
                        input_function_enable     <= 1'b0;
                        powerup_run_select        <= 1'b0;
                        lock_level                <= `SLS_RST_LOCK;
                        nonvolatile_write_inhibit <= 1'b0;
                        primary_output_mode       <= `SLS_RST_OUTMODE;
                        target_value              <= `SLS_RST_TARGET;
                        param_value               <= `SLS_RST_PARAM;
                        state                     <= SLS_IDLE;
                    end
                    if (contact_active) run_state <= contact_input_in[0];
                end
                default: state <= SLS_LOAD;
            endcase
        end
    end

    // ====================================================
    // Contact decode outputs
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            target_select_out     <= 2'h0;
            alarm_latch_reset_out <= 1'b0;
        end else begin
            target_select_out     <= contact_active ? next_target : 2'h0;
            alarm_latch_reset_out <= contact_active & four & contact_input_in[3];
        end
    end

    // ====================================================
    // Panel lock indicator and commit strobe
    wire panel_locked_edit = key_set_in & (lock_level != 2'h0);
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            blink              <= 1'b0;
            key_lock_q         <= 1'b0;
            nv_commit_out      <= 1'b0;
            nv_commit_addr_out <= 4'h0;
        end else begin
            key_lock_q <= key_lock_combo_in;
            if (panel_locked_edit) blink <= 1'b1;
            else if (key_clear_in) blink <= 1'b0;
            nv_commit_out <= next_commit | restore_yes;
            if (next_commit || restore_yes) nv_commit_addr_out <= restore_yes ? 4'hF : addr;
        end
    end

    assign run_out                 = run_state;
    assign primary_output_mode_out = primary_output_mode;
    assign lock_blink_out          = blink;

    // ====================================================
    // Checks
    lock_one_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_go && lock_level == 2'h1 && addr == `SLS_OFF_PARAM) |=> $stable(param_value))
        else $error("locked write changed parameter");
    contact_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!contact_active) |=> (target_select_out == 2'h0 && !alarm_latch_reset_out))
        else $error("contacts acted while disabled");
    inhibit_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_ok && nonvolatile_write_inhibit && addr == `SLS_OFF_PARAM) |=> !nv_commit_out)
        else $error("commit under inhibit");
    lock_commit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_ok && addr == `SLS_OFF_LOCK) |=> nv_commit_out)
        else $error("lock write not committed");
    sequence restore_open_s;
        wr_ok && addr == `SLS_OFF_RESTORE && !restore_req && wd[0];
    endsequence
    restore_wait_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        restore_open_s |=> (restore_req && $stable(param_value)))
        else $error("restore acted without confirm");
    restore_yes_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        restore_yes |=> (param_value == `SLS_RST_PARAM && lock_level == `SLS_RST_LOCK))
        else $error("restore incomplete");
    panel_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state != SLS_LOAD && key_lock_combo_in && !key_lock_q) |=> lock_level == `SLS_LOCK_PANEL)
        else $error("panel lock not level two");
    blink_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (key_clear_in && !panel_locked_edit) |=> !lock_blink_out)
        else $error("blink not cleared");
    latch_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (contact_active && four && contact_input_in[3]) |=> alarm_latch_reset_out)
        else $error("latch reset missed");
    powerup_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == SLS_LOAD) |=> run_out == $past(nv_powerup_run_in))
        else $error("power-up state wrong");

    // ====================================================
    // Handshake and multi-step checks
    sequence take_s;
        req && ready;
    endsequence
    sequence restore_pending_s;
        restore_req && state == SLS_CONFIRM;
    endsequence
    one_wait_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        take_s |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("answer not after one wait");
    load_wait_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (req && state == SLS_LOAD) |-> avs_waitrequest_out)
        else $error("answered before reload");
    abandon_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (restore_pending_s ##0 restore_no) |=> (!restore_req && $stable(param_value)))
        else $error("abandon changed state");
    yes_restore_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (restore_pending_s ##0 restore_yes) |=> (!restore_req && primary_output_mode == `SLS_RST_OUTMODE))
        else $error("restore left mode");
    restore_commit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        restore_yes |=> (nv_commit_out && nv_commit_addr_out == 4'hF))
        else $error("restore not committed");
    reload_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == SLS_LOAD) |=> (param_value == $past(nv_param_in) && lock_level == $past(nv_lock_in)))
        else $error("reload missed");
    level_two_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_go && lock_level == 2'h2 && addr == `SLS_OFF_TARGET) |=> target_value == $past(wd))
        else $error("target refused at level two");
    level_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_go && lock_level == 2'h0 && addr == `SLS_OFF_PARAM) |=> param_value == $past(wd))
        else $error("write refused at level zero");
    lock_value_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_ok && addr == `SLS_OFF_LOCK && wd[1:0] == 2'h3 && !(key_lock_combo_in && !key_lock_q))
        |=> $stable(lock_level))
        else $error("lock took level three");
    read_locked_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (rd_go && addr == `SLS_OFF_PARAM) |=> avs_readdata_out[DW-1:0] == $past(param_value))
        else $error("parameter read wrong");
    inhibit_commit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_ok && addr == `SLS_OFF_INHIBIT) |=> (nv_commit_out && nv_commit_addr_out == `SLS_OFF_INHIBIT))
        else $error("inhibit write not committed");
    out_mode_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (wr_ok && addr == `SLS_OFF_OUTMODE) |=> primary_output_mode_out == $past(wd[0]))
        else $error("output mode not taken");
    run_follow_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (contact_active && state != SLS_LOAD) |=> run_out == $past(contact_input_in[0]))
        else $error("run does not follow input one");
    two_target_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (contact_active && !four) |=> target_select_out == {2{$past(contact_input_in[1])}})
        else $error("two-input target wrong");
    four_target_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (contact_active && four)
        |=> target_select_out == {$past(contact_input_in[2]), $past(contact_input_in[1])})
        else $error("four-input target wrong");
    alarm_two_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (!four) |=> !alarm_latch_reset_out)
        else $error("latch reset without input four");
    blink_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
        panel_locked_edit |=> lock_blink_out)
        else $error("blink not raised");
endmodule

//--- testbench/sls_field_model.sv
// Field contacts and stored parameter copy facing the setup lock block
`timescale 1ns/10ps
module sls_field_model #(
    parameter logic [15:0] NV_PARAM = 16'h00A5    // Stored parameter value
) (
    input  wire logic        clk_in,       // System clock
    input  wire logic [3:0]  pattern_in,   // Contact levels wanted
    output logic      [3:0]  contact_out,  // Contact levels seen
    output logic      [15:0] nv_param_out  // Stored parameter copy
);
    logic [3:0] level = 4'h0;
    // Switches move just after an edge, never mid-cycle
    always @(posedge clk_in) begin
        level <= pattern_in;
    end
    assign contact_out  = level;
    assign nv_param_out = NV_PARAM;
endmodule

//--- testbench/tb.sv
// Self-checking bench of the setup lock block
`timescale 1ns/10ps
`include "sls_consts.svh"
module tb;
    import sls_pkg::*;
    logic        clk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    sls_opt_t    opt = SLS_OPT_FOUR;
    logic [3:0]  pattern = 4'h0;
    logic [3:0]  contacts;
    logic [15:0] nv_param;
    logic        po_run = 1'b1;
    logic        k_combo = 1'b0;
    logic        k_set = 1'b0;
    logic        k_clr = 1'b0;
    logic        run, alr, pmode, blink, commit;
    logic [1:0]  tsel;
    logic [3:0]  caddr;
    logic [31:0] rd;
    logic        cm;
    logic [3:0]  ca;
    int          fails = 0;
    int          n_tests = 0;
    sls_field_model sls_field_model_inst (.clk_in(clk_in), .pattern_in(pattern), .contact_out(contacts),
        .nv_param_out(nv_param));
    sls_setup_lock sls_setup_lock_inst (.clk_in(clk_in), .rstn_in(rstn_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .contact_option_in(opt), .contact_input_in(contacts), .nv_setup_in(1'b0),
        .nv_powerup_run_in(po_run), .nv_lock_in(2'h0), .nv_inhibit_in(1'b0), .nv_target_in(16'h0000),
        .nv_param_in(nv_param), .key_lock_combo_in(k_combo), .key_set_in(k_set), .key_clear_in(k_clr),
        .run_out(run), .target_select_out(tsel), .alarm_latch_reset_out(alr),
        .primary_output_mode_out(pmode), .lock_blink_out(blink), .nv_commit_out(commit),
        .nv_commit_addr_out(caddr));
    // ==========================================================
    // Clock and common tasks
    initial begin
        forever #25 clk_in = ~clk_in;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Request holds until waitrequest is sampled low; the commit pulse leaves on that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_in);
        avs_address_in <= a;
        avs_write_in <= w;
        avs_read_in <= !w;
        avs_writedata_in <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_in);
            if (avs_waitrequest_out === 1'b0) break;
        end
        if (i == 50) begin
            fails++;
            finish_test();
        end
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(negedge clk_in);
        cm = commit;
        ca = caddr;
    endtask
    task automatic rchk(input string name, input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask
    task automatic do_reset();
        rstn_in <= 1'b0;
        repeat (20) @(posedge clk_in);
        rstn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
    endtask
    task automatic pins(input logic [3:0] p, input logic r, input logic [1:0] t, input logic a);
        pattern <= p;
        repeat (4) @(posedge clk_in);
        check("run", run, r);
        check("target", tsel, t);
        check("alarm", alr, a);
    endtask
    // ==========================================================
    // Scenarios
    task automatic s_contacts();
        int k;
        check("powerup run", run, 1'b1);
        check("mode reset", pmode, `SLS_RST_OUTMODE);
        rchk("lock reset", `SLS_OFF_LOCK, 32'h0);
        pins(4'hE, 1'b1, 2'h0, 1'b0);
        bus(1'b1, `SLS_OFF_SETUP, 32'h3);
        for (k = 0; k < 4; k++) begin
            pins({k[1], k[1], k[0], k[0] ^ k[1]}, k[0] ^ k[1], k[1:0], k[1]);
        end
        opt <= SLS_OPT_TWO;
        pins(4'h2, 1'b0, 2'h3, 1'b0);
        pins(4'h1, 1'b1, 2'h0, 1'b0);
        opt <= SLS_OPT_NONE;
        pins(4'h0, 1'b1, 2'h0, 1'b0);
        $display("Contact decode test done");
    endtask
    task automatic s_lock();
        bus(1'b1, `SLS_OFF_OUTMODE, 32'h0);
        repeat (2) @(posedge clk_in);
        check("mode onoff", pmode, 1'b0);
        bus(1'b1, `SLS_OFF_OUTMODE, 32'h1);
        bus(1'b1, `SLS_OFF_LOCK, 32'h1);
        bus(1'b1, `SLS_OFF_OUTMODE, 32'h0);
        bus(1'b1, `SLS_OFF_TARGET, 32'h1234);
        check("mode locked", pmode, 1'b1);
        rchk("mode read", `SLS_OFF_OUTMODE, 32'h1);
        rchk("target l1", `SLS_OFF_TARGET, 32'h0);
        bus(1'b1, `SLS_OFF_LOCK, 32'h2);
        bus(1'b1, `SLS_OFF_TARGET, 32'h1234);
        bus(1'b1, `SLS_OFF_PARAM, 32'h0055);
        rchk("target l2", `SLS_OFF_TARGET, 32'h1234);
        rchk("param l2", `SLS_OFF_PARAM, {16'h0, nv_param});
        bus(1'b1, `SLS_OFF_LOCK, 32'h0);
        k_combo <= 1'b1;
        repeat (3) @(posedge clk_in);
        k_combo <= 1'b0;
        rchk("panel lock", `SLS_OFF_LOCK, {30'h0, `SLS_LOCK_PANEL});
        k_set <= 1'b1;
        @(posedge clk_in);
        k_set <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("blink on", blink, 1'b1);
        k_clr <= 1'b1;
        @(posedge clk_in);
        k_clr <= 1'b0;
        repeat (3) @(posedge clk_in);
        check("blink off", blink, 1'b0);
        bus(1'b1, `SLS_OFF_LOCK, 32'h0);
        $display("Lock test done");
    endtask
    task automatic s_inhibit();
        // host inhibits before a write burst
        bus(1'b1, `SLS_OFF_INHIBIT, 32'h1);
        check("inh commit", {cm, ca}, {1'b1, `SLS_OFF_INHIBIT});
        bus(1'b1, `SLS_OFF_PARAM, 32'h0077);
        check("param commit", cm, 1'b0);
        rchk("param ram", `SLS_OFF_PARAM, 32'h0077);
        bus(1'b1, `SLS_OFF_LOCK, 32'h0);
        check("lock commit", {cm, ca}, {1'b1, `SLS_OFF_LOCK});
        po_run <= 1'b0;
        do_reset();
        rchk("reload", `SLS_OFF_PARAM, {16'h0, nv_param});
        check("powerup stop", run, 1'b0);
        $display("Inhibit test done");
    endtask
    task automatic s_restore();
        bus(1'b1, `SLS_OFF_PARAM, 32'h0077);
        bus(1'b1, `SLS_OFF_OUTMODE, 32'h0);
        bus(1'b1, `SLS_OFF_RESTORE, 32'h1);
        rchk("no restore", `SLS_OFF_PARAM, 32'h0077);
        bus(1'b0, `SLS_OFF_RESTORE, 32'h0);
        check("pending", rd[`SLS_BIT_CONFIRM], 1'b1);
        bus(1'b1, `SLS_OFF_RESTORE, {30'h0, `SLS_CONF_NO});
        rchk("abandon", `SLS_OFF_PARAM, 32'h0077);
        bus(1'b0, `SLS_OFF_RESTORE, 32'h0);
        check("cleared", rd[`SLS_BIT_CONFIRM], 1'b0);
        bus(1'b1, `SLS_OFF_RESTORE, 32'h1);
        bus(1'b1, `SLS_OFF_RESTORE, {30'h0, `SLS_CONF_YES});
        check("restore commit", {cm, ca}, 5'h1F);
        rchk("def param", `SLS_OFF_PARAM, {16'h0, `SLS_RST_PARAM});
        repeat (2) @(posedge clk_in);
        check("def mode", pmode, `SLS_RST_OUTMODE);
        $display("Restore test done");
    endtask
    initial begin
        do_reset();
        s_contacts();
        s_lock();
        s_inhibit();
        s_restore();
        finish_test();
    end
endmodule
